// >>> sdp_data_port.sv
// data port: link modes, rate dividers, demodulator, filter clocks
`timescale 1ns/1ps
module sdp_data_port
	import sdp_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [6:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic iChanSign,
	input wire logic qChanSign,
	input wire logic bidirDataLineIn,
	output logic bidirDataLineOut,
	output logic bidirDataLineOe,
	output logic linkBitClockOut,
	output logic linkBitClockOe,
	output logic modBitValid,
	input wire logic modBitReady,
	output logic modBitOut,
	output logic frontAmpBypass,
	output logic [1:0] prefilterCorner,
	output logic [8:0] prefilterCornerKhz,
	output logic filterPhase1,
	output logic filterPhase2,
	output logic symbolRateTick,
	output logic resyncTick
);
	// ====================================================================
	// helpers
	// divisor of zero behaves as one
	function automatic logic [5:0] effDiv(input logic [5:0] d);
		effDiv = (d == 6'h00) ? 6'h01 : d;
	endfunction

	// true when the low (7-e) bits of the count are all ones
	function automatic logic periodEnd(input logic [6:0] c, input logic [2:0] e);
		logic [6:0] mask;
		mask = 7'h7F >> e;
		periodEnd = &(c | ~mask);
	endfunction

	// ====================================================================
	// registers on the programming port
	logic [7:0] modeReg_q, modPfReg_q, rateHiReg_q, rateLoReg_q, filterReg_q;
	logic [7:0] regRdData_q;
	wire wrMode = regWrEn && (regAddr == ADDR_MODE);
	wire wrModPf = regWrEn && (regAddr == ADDR_MODPF);
	wire wrRateHi = regWrEn && (regAddr == ADDR_RATE_HI);
	wire wrRateLo = regWrEn && (regAddr == ADDR_RATE_LO);
	wire wrFilter = regWrEn && (regAddr == ADDR_FILTER);
	wire restart = wrMode || wrRateHi || wrRateLo || wrFilter;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			modeReg_q <= RST_MODE;
			modPfReg_q <= RST_MODPF;
			rateHiReg_q <= RST_RATE_HI;
			rateLoReg_q <= RST_RATE_LO;
			filterReg_q <= RST_FILTER;
		end else begin
			if (wrMode) modeReg_q <= regWrData;
			if (wrModPf) modPfReg_q <= regWrData;
			if (wrRateHi) rateHiReg_q <= regWrData;
			if (wrRateLo) rateLoReg_q <= regWrData;
			if (wrFilter) filterReg_q <= regWrData | FILTER_FIXED;
		end
	end

	// read data, one cycle after the strobe; unmapped reads give zero
	logic [7:0] rdMux;
	assign rdMux = (regAddr == ADDR_MODE) ? modeReg_q :
		(regAddr == ADDR_MODPF) ? modPfReg_q :
		(regAddr == ADDR_RATE_HI) ? rateHiReg_q :
		(regAddr == ADDR_RATE_LO) ? rateLoReg_q :
		(regAddr == ADDR_FILTER) ? filterReg_q : 8'h00;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) regRdData_q <= 8'h00;
		else if (regRdEn) regRdData_q <= rdMux;
	end
	assign regRdData = regRdData_q;

	// ====================================================================
	// field decode and link mode
	wire syncEn = modeReg_q[POS_SYNC];
	wire [1:0] opState = modeReg_q[POS_STATE +: 2];
	wire [2:0] rateSel = {rateHiReg_q[POS_RATE_MSB], rateLoReg_q[POS_RATE_LSB +: 2]};
	wire [2:0] resyncSel = rateHiReg_q[POS_RESYNC +: 3];
	wire [5:0] refDiv = effDiv(rateLoReg_q[POS_REFDIV +: 6]);
	wire [5:0] scDiv = effDiv(filterReg_q[POS_SCDIV +: 6]);
	wire [2:0] rateSelC = (rateSel > RATE_SEL_MAX) ? RATE_SEL_MAX : rateSel;

	sdp_link_t linkMode;
	assign linkMode = (opState == STATE_RX) ? (syncEn ? LNK_RX_SYNC : LNK_RX_TRANS) :
		(opState == STATE_TX) ? (syncEn ? LNK_TX_SYNC : LNK_TX_TRANS) : LNK_IDLE;
	wire rxSync = (linkMode == LNK_RX_SYNC);
	wire txSync = (linkMode == LNK_TX_SYNC);
	wire rxMode = rxSync || (linkMode == LNK_RX_TRANS);

	// static controls for the analog side
	assign frontAmpBypass = modeReg_q[POS_BYPASS];
	assign prefilterCorner = modPfReg_q[POS_PF +: 2];
	always_comb begin
		case (prefilterCorner)
			2'h0: prefilterCornerKhz = CORNER_0_KHZ;
			2'h1: prefilterCornerKhz = CORNER_1_KHZ;
			2'h2: prefilterCornerKhz = CORNER_2_KHZ;
			default: prefilterCornerKhz = CORNER_3_KHZ;
		endcase
	end

	// ====================================================================
	// input synchronisers for pins
	logic [1:0] iSyn_q, qSyn_q, dSyn_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			iSyn_q <= 2'h0;
			qSyn_q <= 2'h0;
			dSyn_q <= 2'h0;
		end else begin
			iSyn_q <= {iSyn_q[0], iChanSign};
			qSyn_q <= {qSyn_q[0], qChanSign};
			dSyn_q <= {dSyn_q[0], bidirDataLineIn};
		end
	end
	wire iNow = iSyn_q[1];
	wire qNow = qSyn_q[1];
	wire txPinNow = dSyn_q[1];

	// demodulator: on each I edge, I equal to Q means I lags Q
	logic iPrev_q, demod_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			iPrev_q <= 1'b0;
			demod_q <= 1'b0;
		end else begin
			iPrev_q <= iNow;
			if (iNow != iPrev_q) demod_q <= ~(iNow ^ qNow);
		end
	end

	// ====================================================================
	// reference divider K, then a power-of-two chain shared by rate/resync
	logic fifoInReady;
	logic [5:0] kCnt_q;
	logic [6:0] divCnt_q;
	wire stall = txSync && !fifoInReady;
	wire prescaleTick = (kCnt_q >= refDiv) && !stall;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			kCnt_q <= 6'h01;
			divCnt_q <= 7'h00;
		end else if (restart) begin
			kCnt_q <= 6'h01;
			divCnt_q <= 7'h00;
		end else if (prescaleTick) begin
			kCnt_q <= 6'h01;
			divCnt_q <= divCnt_q + 7'h01;
		end else if (!stall) begin
			kCnt_q <= kCnt_q + 6'h01;
		end
	end
	assign symbolRateTick = prescaleTick && periodEnd(divCnt_q, rateSel);
	assign resyncTick = prescaleTick && periodEnd(divCnt_q, resyncSel);

	// square bit-rate level: bit (6-s) of the chain, half high half low
	wire rateLevel = divCnt_q[3'(RATE_SEL_MAX - rateSelC)];

	// ====================================================================
	// receive bit resync: 16 phases per bit, realigned on data edges
	logic [3:0] phase_q;
	logic demodPrev_q, rxClk_q, rxBit_q;
	wire [3:0] phaseNext = (demod_q != demodPrev_q) ? 4'h0 : phase_q + 4'h1;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 4'h0;
			demodPrev_q <= 1'b0;
			rxClk_q <= 1'b0;
			rxBit_q <= 1'b0;
		end else if (!rxSync || restart) begin
			phase_q <= 4'h0;
			rxClk_q <= 1'b0;
		end else if (resyncTick) begin
			demodPrev_q <= demod_q;
			phase_q <= phaseNext;
			rxClk_q <= (phaseNext >= RESYNC_MID);
			if (phaseNext == RESYNC_MID) rxBit_q <= demod_q;
		end
	end

	// ====================================================================
	// link pins: clock driven only in sync modes, device is master
	logic pinClk_q, pinData_q;
	wire txRise = txSync && rateLevel && !pinClk_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pinClk_q <= 1'b0;
			pinData_q <= 1'b0;
		end else begin
			if (restart) pinClk_q <= 1'b0;
			else if (txSync) pinClk_q <= rateLevel;
			else if (rxSync) pinClk_q <= rxClk_q;
			else pinClk_q <= 1'b0;
			pinData_q <= rxSync ? rxBit_q : demod_q;
		end
	end
	assign linkBitClockOut = pinClk_q;
	assign linkBitClockOe = rxSync || txSync;
	assign bidirDataLineOut = pinData_q;
	assign bidirDataLineOe = rxMode;

	// ====================================================================
	// transmit path: bits sampled on clock rise go through the fifo;
	// a full fifo stops the clock so the host is throttled
	logic fifoOutValid, fifoOutData;
	sdp_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) txFifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.flush(!txSync),
		.inValid(txRise),
		.inReady(fifoInReady),
		.inData(txPinNow),
		.outValid(fifoOutValid),
		.outReady(modBitReady && txSync),
		.outData(fifoOutData)
	);
	assign modBitValid = txSync ? fifoOutValid : (linkMode == LNK_TX_TRANS);
	assign modBitOut = txSync ? fifoOutData : txPinNow;

	// ====================================================================
	// switched-capacitor clock: divide by divisor, then by four phases
	logic [5:0] scCnt_q;
	logic [1:0] scPhase_q;
	logic ph1_q, ph2_q;
	wire scTick = (scCnt_q >= scDiv);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scCnt_q <= 6'h01;
			scPhase_q <= 2'h0;
			ph1_q <= 1'b0;
			ph2_q <= 1'b0;
		end else if (restart) begin
			scCnt_q <= 6'h01;
			scPhase_q <= 2'h0;
			ph1_q <= 1'b0;
			ph2_q <= 1'b0;
		end else begin
			scCnt_q <= scTick ? 6'h01 : scCnt_q + 6'h01;
			if (scTick) begin
				scPhase_q <= scPhase_q + 2'h1;
				ph1_q <= (scPhase_q + 2'h1 == FILTER_PH1);
				ph2_q <= (scPhase_q + 2'h1 == FILTER_PH2);
			end
		end
	end
	assign filterPhase1 = ph1_q;
	assign filterPhase2 = ph2_q;

	// ====================================================================
	// checks: helper counters measure periods of the divided clocks
	logic [15:0] rateGap_q, phGap_q;
	logic rateGapOk_q, phGapOk_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rateGap_q <= 16'h0001;
			rateGapOk_q <= 1'b0;
			phGap_q <= 16'h0001;
			phGapOk_q <= 1'b0;
		end else begin
			rateGap_q <= (restart || symbolRateTick) ? 16'h0001 : rateGap_q + 16'h0001;
			if (restart || stall) rateGapOk_q <= 1'b0;
			else if (symbolRateTick) rateGapOk_q <= 1'b1;
			phGap_q <= (restart || $rose(ph1_q)) ? 16'h0001 : phGap_q + 16'h0001;
			if (restart) phGapOk_q <= 1'b0;
			else if ($rose(ph1_q)) phGapOk_q <= 1'b1;
		end
	end
	wire [15:0] ratePeriod = 16'(refDiv) << (EXP_TOP - rateSel);
	wire [15:0] phPeriod = {8'h00, scDiv, 2'h0};

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_rate_period: assert property (symbolRateTick && rateGapOk_q && !restart |-> rateGap_q == ratePeriod) else $error("bit-rate period wrong");
	a_filter_period: assert property ($rose(ph1_q) && phGapOk_q && !restart |-> phGap_q == phPeriod) else $error("filter phase period wrong");
	a_phase_nonoverlap: assert property (!(ph1_q && ph2_q)) else $error("filter phases overlap");
	a_tx_sample_rise: assert property (txSync && !restart && $rose(rateLevel) |=> $rose(pinClk_q)) else $error("tx clock did not rise");
	a_rx_data_rise: assert property (rxSync && $changed(rxBit_q) && $stable(linkMode) |-> $rose(rxClk_q)) else $error("rx data moved off rising edge");
	a_demod_lag: assert property ($rose(iNow) && qNow |=> demod_q) else $error("lagging I not decoded as one");
	a_demod_lead: assert property ($rose(iNow) && !qNow |=> !demod_q) else $error("leading I not decoded as zero");
	a_bypass_write: assert property (wrMode |=> frontAmpBypass == $past(regWrData[POS_BYPASS])) else $error("bypass not taken from write");
	a_corner_230: assert property (prefilterCorner == 2'h2 |-> prefilterCornerKhz == 9'h0E6) else $error("corner code wrong");
	a_restart_low: assert property (restart |=> !pinClk_q && divCnt_q == 7'h00) else $error("restart left clock high");
	a_clock_oe_sync: assert property (!(rxSync || txSync) |-> !linkBitClockOe ##1 !pinClk_q || restart) else $error("clock pin on outside sync");
	a_resync_mid: assert property (rxSync && !restart && resyncTick && phase_q == 4'h7 && demod_q == demodPrev_q |=> rxClk_q) else $error("resync midpoint missed");

	c_tx_push: cover property (txRise && fifoInReady);
	c_tx_full_stall: cover property (txSync && !fifoInReady);
	c_rx_sync_bit: cover property (rxSync && $rose(rxClk_q));
	c_filter_cycle: cover property ($rose(ph2_q));
endmodule

// >>> sdp_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdp_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;

	// ====================================================================
	// honest full and empty from the fill count
	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem_q[rdPtr_q];

	// storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// pointers wrap at the depth
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else if (flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> sdp_host_model.sv
// host model: sends tx bits and samples rx bits on device clock falls
`timescale 1ns/1ps
module sdp_host_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic linkBitClock,
	input wire logic lineLevel,
	input wire logic sendEn,
	input wire logic [7:0] txPattern,
	output logic hostOut,
	output logic hostOe,
	output logic rxSample,
	output logic [3:0] sentCount
);
	logic clkPrev;
	// ==========
	// act once per falling edge of the device clock
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			clkPrev <= 1'b0;
			hostOe <= 1'b0;
			hostOut <= 1'b0;
			rxSample <= 1'b0;
			sentCount <= 4'h0;
		end else begin
			clkPrev <= linkBitClock;
			if (clkPrev && !linkBitClock) begin
				rxSample <= lineLevel;
				hostOe <= sendEn; // tristate until sending
				if (sendEn) begin
					hostOut <= txPattern[sentCount[2:0]];
					sentCount <= sentCount + 4'h1;
				end
			end
		end
	end
endmodule

// >>> sdp_pkg.sv
// constants, field positions and state codes for the synchronous data port
package sdp_pkg;
	// ====================================================================
	// register indices on the programming port
	localparam logic [6:0] ADDR_MODE = 7'h00;
	localparam logic [6:0] ADDR_MODPF = 7'h01;
	localparam logic [6:0] ADDR_RATE_HI = 7'h06;
	localparam logic [6:0] ADDR_RATE_LO = 7'h07;
	localparam logic [6:0] ADDR_FILTER = 7'h08;
	// ====================================================================
	// field positions
	localparam int POS_BYPASS = 7;
	localparam int POS_SYNC = 3;
	localparam int POS_STATE = 1;
	localparam int POS_PF = 0;
	localparam int POS_RATE_MSB = 0;
	localparam int POS_RESYNC = 1;
	localparam int POS_RATE_LSB = 6;
	localparam int POS_REFDIV = 0;
	localparam int POS_SCDIV = 0;
	// ====================================================================
	// reset values; the two top bits of the filter register read as one
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_MODPF = 8'h00;
	localparam logic [7:0] RST_RATE_HI = 8'h00;
	localparam logic [7:0] RST_RATE_LO = 8'h01;
	localparam logic [7:0] RST_FILTER = 8'hC1;
	localparam logic [7:0] FILTER_FIXED = 8'hC0;
	// ====================================================================
	// operating state codes and timing counts
	localparam logic [1:0] STATE_RX = 2'h2;
	localparam logic [1:0] STATE_TX = 2'h3;
	localparam logic [2:0] RATE_SEL_MAX = 3'h6;
	localparam logic [2:0] EXP_TOP = 3'h7;
	localparam logic [3:0] RESYNC_MID = 4'h8;
	localparam logic [1:0] FILTER_PH1 = 2'h0;
	localparam logic [1:0] FILTER_PH2 = 2'h2;
	localparam logic [8:0] CORNER_0_KHZ = 9'h064;
	localparam logic [8:0] CORNER_1_KHZ = 9'h096;
	localparam logic [8:0] CORNER_2_KHZ = 9'h0E6;
	localparam logic [8:0] CORNER_3_KHZ = 9'h154;
	// ====================================================================
	// link modes, one-hot
	typedef enum logic [4:0] {
		LNK_IDLE = 5'h01,
		LNK_RX_TRANS = 5'h02,
		LNK_RX_SYNC = 5'h04,
		LNK_TX_TRANS = 5'h08,
		LNK_TX_SYNC = 5'h10
	} sdp_link_t;
endpackage

// >>> sync_data_port_and_filter_clocks_bench.sv
// testbench for the synchronous data port
`timescale 1ns/1ps
module sync_data_port_and_filter_clocks_bench
	import sdp_pkg::*;
;
	localparam int K = 5;
	localparam int RATE_P = K * 16;
	localparam int SYNC_P = K;
	localparam int FILT_P = 4 * 3;
	localparam logic [7:0] PATTERN = 8'hB4;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [6:0] regAddr = 7'h00;
	logic [7:0] regWrData = 8'h00;
	logic iChanSign = 1'b0;
	logic qChanSign = 1'b0;
	logic modBitReady = 1'b1;
	logic sendEn = 1'b0;
	logic floatBit = 1'b0;
	logic [7:0] regRdData;
	logic devOut, devOe, clkOut, clkOe, modBitValid, modBitOut, bypass;
	logic ph1, ph2, rateTick, syncTick, hostOut, hostOe, rxSample;
	logic [1:0] corner;
	logic [8:0] cornerKhz;
	logic [3:0] sentCount;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	// released line shows a changing pattern, device wins over host
	wire lineLevel = devOe ? devOut : (hostOe ? hostOut : floatBit);
	sdp_data_port uut (.core_clk(core_clk), .nrst(nrst),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData),
		.iChanSign(iChanSign), .qChanSign(qChanSign),
		.bidirDataLineIn(lineLevel), .bidirDataLineOut(devOut),
		.bidirDataLineOe(devOe), .linkBitClockOut(clkOut),
		.linkBitClockOe(clkOe), .modBitValid(modBitValid),
		.modBitReady(modBitReady), .modBitOut(modBitOut),
		.frontAmpBypass(bypass), .prefilterCorner(corner),
		.prefilterCornerKhz(cornerKhz), .filterPhase1(ph1),
		.filterPhase2(ph2), .symbolRateTick(rateTick),
		.resyncTick(syncTick));
	sdp_host_model host (.core_clk(core_clk), .nrst(nrst),
		.linkBitClock(clkOut), .lineLevel(lineLevel), .sendEn(sendEn),
		.txPattern(PATTERN), .hostOut(hostOut), .hostOe(hostOe),
		.rxSample(rxSample), .sentCount(sentCount));
	// ==========
	// clock, idle line pattern and hang guard
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		floatBit <= ~floatBit;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end
	// ==========
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		cyc(1);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		cyc(1);
		regWrEn = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		cyc(1);
		regRdEn = 1'b1;
		regAddr = a;
		cyc(1);
		regRdEn = 1'b0;
		check(16'(regRdData), 16'(exp));
	endtask
	// cycles between rising edges of a tick or phase output
	task automatic period(input int sel, input int exp);
		logic prev, cur;
		int t0, p;
		prev = 1'b1;
		t0 = -1;
		p = 0;
		for (int i = 0; i < 400 && p == 0; i++) begin
			cyc(1);
			cur = sel == 0 ? rateTick : (sel == 1 ? syncTick :
				(sel == 2 ? ph1 : ph2));
			if (cur && !prev && t0 >= 0) p = i - t0;
			if (cur && !prev) t0 = i;
			prev = cur;
		end
		check(16'(p), 16'(exp));
	endtask
	// ==========
	// scenarios
	task automatic t_regs();
		wr(7'h02, 8'hFF); // unmapped, dropped
		rd(7'h02, 8'h00);
		rd(ADDR_MODE, RST_MODE);
		rd(ADDR_MODPF, RST_MODPF);
		rd(ADDR_RATE_HI, RST_RATE_HI);
		rd(ADDR_RATE_LO, RST_RATE_LO);
		rd(ADDR_FILTER, RST_FILTER);
		wr(ADDR_FILTER, 8'h03);
		rd(ADDR_FILTER, 8'hC3);
	endtask
	task automatic t_modes();
		logic [8:0] khz [4];
		khz = '{CORNER_0_KHZ, CORNER_1_KHZ, CORNER_2_KHZ, CORNER_3_KHZ};
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_MODPF, 8'(c));
			check(16'(corner), 16'(c));
			check(16'(cornerKhz), 16'(khz[c]));
		end
		wr(ADDR_MODE, 8'h80);
		check(16'(bypass), 16'h1);
		wr(ADDR_MODE, 8'h06); // transmit, transparent
		check(16'(clkOe), 16'h0);
		check(16'(modBitValid), 16'h1);
	endtask
	task automatic t_dividers();
		wr(ADDR_RATE_HI, 8'h0E); // resync exponent 7, rate msb 0
		wr(ADDR_RATE_LO, 8'hC5); // rate exponent 3, divisor 5
		period(0, RATE_P);
		period(1, SYNC_P);
		period(2, FILT_P);
		period(3, FILT_P);
	endtask
	task automatic t_tx();
		int i, n, bad;
		logic lvl;
		wr(ADDR_MODE, 8'h0E); // transmit, synchronous
		check(16'(clkOe), 16'h1);
		check(16'(devOe), 16'h0);
		sendEn = 1'b1;
		for (n = 0; n < 2000 && sentCount == 4'h0; n++) cyc(1);
		i = 0;
		for (n = 0; n < 2000 && i < 8; n++) begin
			cyc(1);
			if (modBitValid && modBitReady) begin
				check(16'(modBitOut), 16'(PATTERN[i]));
				i++;
			end
		end
		cyc(1);
		modBitReady = 1'b0;
		cyc(800);
		lvl = clkOut;
		bad = 0;
		for (n = 0; n < 100; n++) begin
			cyc(1);
			if (clkOut !== lvl) bad++;
		end
		check(16'(bad), 16'h0); // clock frozen while fifo full
		check(16'(modBitValid), 16'h1);
		modBitReady = 1'b1;
		i = 0;
		for (n = 0; n < 20 && i < 8; n++) begin
			if (modBitValid) check(16'(modBitOut), 16'(PATTERN[i]));
			if (modBitValid) i++;
			cyc(1);
		end
		check(16'(i), 16'h8);
		sendEn = 1'b0;
	endtask
	task automatic t_rx();
		wr(ADDR_MODE, 8'h04); // receive, transparent
		// Q low: I rise leads (0), I fall lags (1); Q high: rise lags (1),
		// fall leads (0)
		for (int b = 0; b < 4; b++) begin
			qChanSign = (b >= 2);
			iChanSign = ~iChanSign;
			cyc(8);
			check(16'(devOut), 16'(b == 1 || b == 2));
		end
		check(16'(clkOe), 16'h0);
		check(16'(devOe), 16'h1);
		wr(ADDR_MODE, 8'h0C); // receive, synchronous
		for (int b = 0; b < 2; b++) begin
			iChanSign = ~iChanSign;
			cyc(300);
			check(16'(rxSample), 16'(iChanSign));
		end
		check(16'(clkOe), 16'h1);
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		#1 nrst = 1'b1;
		t_regs();
		t_modes();
		t_dividers();
		t_tx();
		t_rx();
		results();
	end
endmodule
